// ---- sdp_port.sv ----
// device side of a separate-io double-rate burst-of-two sram port
`include "sdp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sdp_port #(
  parameter  int DATA_W   = 36,
  parameter  int ADDR_W   = `SDP_ADDR_W36,
  parameter  int MEM_AW   = 8,
  localparam int LANE_W   = (DATA_W == `SDP_WORD_W8) ? `SDP_NIBBLE_W : `SDP_BYTE_W,
  localparam int MASK_W   = (DATA_W + LANE_W - 1) / LANE_W
) (
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  input  wire logic                 clk_en,
  input  wire logic                 k_phase,
  input  wire logic                 c_phase,
  input  wire logic                 single_clk_mode,
  input  wire logic                 load_strobe_n,
  input  wire logic                 read_not_write,
  input  wire logic [ADDR_W-1:0]    addr,
  input  wire logic [DATA_W-1:0]    wr_data,
  input  wire logic [MASK_W-1:0]    write_mask_n,
  output logic      [DATA_W-1:0]    rd_data,
  output logic                      rd_data_oe_n
);
  localparam int IDX_W  = (MEM_AW < ADDR_W) ? MEM_AW : ADDR_W;

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [1:0] k_s_r, c_s_r, sc_s_r, ld_s_r, rw_s_r;
  logic [ADDR_W-1:0] a_s1_r, a_s2_r;
  logic [DATA_W-1:0] d_s1_r, d_s2_r;
  logic [MASK_W-1:0] m_s1_r, m_s2_r;

  // two flops on every pin but reset_n and clk_en before any logic looks at it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      k_s_r  <= 2'h0;
      c_s_r  <= 2'h0;
      sc_s_r <= 2'h0;
      ld_s_r <= 2'h3;
      rw_s_r <= 2'h0;
      a_s1_r <= '0;
      a_s2_r <= '0;
      d_s1_r <= '0;
      d_s2_r <= '0;
      m_s1_r <= '1;
      m_s2_r <= '1;
    end else if (clk_en) begin
      k_s_r  <= {k_s_r[0], k_phase};
      c_s_r  <= {c_s_r[0], c_phase};
      sc_s_r <= {sc_s_r[0], single_clk_mode};
      ld_s_r <= {ld_s_r[0], load_strobe_n};
      rw_s_r <= {rw_s_r[0], read_not_write};
      a_s1_r <= addr;
      a_s2_r <= a_s1_r;
      d_s1_r <= wr_data;
      d_s2_r <= d_s1_r;
      m_s1_r <= write_mask_n;
      m_s2_r <= m_s1_r;
    end
  end

  // ************************************************************
  // edge detection
  // ************************************************************
  logic k_prev_r, c_prev_r;
  logic k_rise, kb_rise, c_rise, cb_rise, o_rise, ob_rise;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      k_prev_r <= 1'b0;
      c_prev_r <= 1'b0;
    end else if (clk_en) begin
      k_prev_r <= k_s_r[1];
      c_prev_r <= c_s_r[1];
    end
  end

  // rising edge of the true clock and of its complement
  always_comb begin
    k_rise  = k_s_r[1] & ~k_prev_r;
    kb_rise = ~k_s_r[1] & k_prev_r;
    c_rise  = c_s_r[1] & ~c_prev_r;
    cb_rise = ~c_s_r[1] & c_prev_r;
    o_rise  = sc_s_r[1] ? k_rise : c_rise;
    ob_rise = sc_s_r[1] ? kb_rise : cb_rise;
  end

  // ************************************************************
  // lane mask expansion
  // ************************************************************
  // one mask bit per lane, active low, widened to bit enables
  function automatic logic [DATA_W-1:0] lane_en(input logic [MASK_W-1:0] m_n);
    logic [DATA_W-1:0] e;
    e = '0;
    for (int i = 0; i < DATA_W; i++) begin
      e[i] = ~m_n[i / LANE_W];
    end
    return e;
  endfunction

  // ************************************************************
  // transaction sequencer
  // ************************************************************
  sdp_pkg::sdp_phase_e phase_r, phase_nxt;
  logic [ADDR_W-1:0] tr_addr_r, tr_addr_nxt;
  logic              half_r, half_nxt;
  logic              rd_pend_r, rd_pend_nxt;
  logic [ADDR_W-1:0] rd_addr_r, rd_addr_nxt;
  logic              mem_we;
  logic [IDX_W:0]    mem_wa;
  logic [DATA_W-1:0] mem_be;
  logic              ld_take;

  // new transaction only at a positive half with load low
  assign ld_take = k_rise && (ld_s_r[1] == `SDP_LOAD_ON);

  always_comb begin
    phase_nxt   = phase_r;
    tr_addr_nxt = tr_addr_r;
    half_nxt    = half_r;
    rd_pend_nxt = rd_pend_r;
    rd_addr_nxt = rd_addr_r;
    mem_we      = 1'b0;
    mem_wa      = {half_r, tr_addr_r[IDX_W-1:0]};
    mem_be      = lane_en(m_s2_r);
    case (phase_r)
      sdp_pkg::SDP_IDLE,
      sdp_pkg::SDP_READ: begin
        phase_nxt = sdp_pkg::SDP_IDLE;
        if (ld_take) begin
          tr_addr_nxt = a_s2_r;
          if (rw_s_r[1] == `SDP_DIR_READ) begin
            phase_nxt   = sdp_pkg::SDP_READ;
            rd_pend_nxt = 1'b1;
            rd_addr_nxt = a_s2_r;
          end else begin
            phase_nxt = sdp_pkg::SDP_WRITE;
            half_nxt  = 1'b0;
            // first word rides the same positive half as the load
            mem_we    = 1'b1;
            mem_wa    = {1'b0, a_s2_r[IDX_W-1:0]};
          end
        end
      end
      sdp_pkg::SDP_WRITE: begin
        // second word on the complement half, masked lanes untouched
        if (kb_rise) begin
          mem_we    = 1'b1;
          mem_wa    = {1'b1, tr_addr_r[IDX_W-1:0]};
          phase_nxt = sdp_pkg::SDP_IDLE;
        end
      end
      default: phase_nxt = sdp_pkg::SDP_IDLE;
    endcase
    if (rd_pend_r && o_rise) begin
      rd_pend_nxt = ld_take && (rw_s_r[1] == `SDP_DIR_READ);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_r   <= sdp_pkg::SDP_IDLE;
      tr_addr_r <= '0;
      half_r    <= 1'b0;
      rd_pend_r <= 1'b0;
      rd_addr_r <= '0;
    end else if (clk_en) begin
      phase_r   <= phase_nxt;
      tr_addr_r <= tr_addr_nxt;
      half_r    <= half_nxt;
      rd_pend_r <= rd_pend_nxt;
      rd_addr_r <= rd_addr_nxt;
    end
  end

  // ************************************************************
  // one internal array, the burst half as its top address bit
  // ************************************************************
  logic [DATA_W-1:0] arr_q;
  logic              out_half_r, out_half_nxt;
  logic [ADDR_W-1:0] out_addr_r, out_addr_nxt;

  sdp_mem #(
    .DATA_W (DATA_W),
    .ADDR_W (IDX_W + 1)
  ) u_mem (
    .ref_clk   (ref_clk),
    .clk_en    (clk_en),
    .wr_en     (mem_we),
    .wr_addr   (mem_wa),
    .wr_data   (d_s2_r),
    .wr_bit_en (mem_be),
    .rd_addr   ({out_half_nxt, out_addr_nxt[IDX_W-1:0]}),
    .rd_data   (arr_q)
  );

  // ************************************************************
  // read output drive
  // ************************************************************
  typedef enum logic [1:0] {
    SDP_OUT_OFF,
    SDP_OUT_W0,
    SDP_OUT_W1
  } sdp_out_e;
  sdp_out_e          out_r, out_nxt;
  logic [DATA_W-1:0] q_r, q_nxt;
  logic              oe_n_r, oe_n_nxt;

  // word 0 on the output positive half, word 1 on the complement
  always_comb begin
    out_nxt      = out_r;
    out_half_nxt = out_half_r;
    out_addr_nxt = out_addr_r;
    q_nxt        = q_r;
    oe_n_nxt     = oe_n_r;
    case (out_r)
      SDP_OUT_OFF: begin
        out_half_nxt = 1'b0;
        // hold the served read's index so a read loaded meanwhile cannot steer word 1
        out_addr_nxt = rd_addr_r;
        oe_n_nxt     = 1'b1;
        if (rd_pend_r && o_rise) begin
          out_nxt = SDP_OUT_W0;
        end
      end
      SDP_OUT_W0: begin
        q_nxt        = arr_q;
        oe_n_nxt     = 1'b0;
        out_half_nxt = 1'b1;
        out_nxt      = SDP_OUT_W1;
      end
      SDP_OUT_W1: begin
        if (ob_rise) begin
          q_nxt   = arr_q;
          out_nxt = SDP_OUT_OFF;
        end
      end
      default: out_nxt = SDP_OUT_OFF;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_r      <= SDP_OUT_OFF;
      out_half_r <= 1'b0;
      out_addr_r <= '0;
      q_r        <= '0;
      oe_n_r     <= 1'b1;
    end else if (clk_en) begin
      out_r      <= out_nxt;
      out_half_r <= out_half_nxt;
      out_addr_r <= out_addr_nxt;
      q_r        <= q_nxt;
      oe_n_r     <= oe_n_nxt;
    end
  end

  assign rd_data      = q_r;
  assign rd_data_oe_n = oe_n_r;
endmodule
`default_nettype wire

// ---- sdp_defs.svh ----
// constants for the separate-io double-rate burst-of-two sram port
`ifndef SDP_DEFS_SVH
`define SDP_DEFS_SVH
`define SDP_BURST_LEN   2
`define SDP_NIBBLE_W    4
`define SDP_BYTE_W      9
`define SDP_WORD_W8     8
`define SDP_ADDR_W8     21
`define SDP_ADDR_W18    20
`define SDP_ADDR_W36    19
`define SDP_LOAD_ON     1'b0
`define SDP_DIR_READ    1'b1
`endif

// ---- sdp_pkg.sv ----
// types shared by the sram port design
package sdp_pkg;
  typedef enum logic [1:0] {
    SDP_IDLE,
    SDP_WRITE,
    SDP_READ
  } sdp_phase_e;
endpackage

// ---- sdp_mem.sv ----
// word array with per-bit write enables and registered read data
`timescale 1ns/1ps
`default_nettype none
module sdp_mem #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 4
) (
  input  wire logic              ref_clk,
  input  wire logic              clk_en,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic [DATA_W-1:0] wr_bit_en,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] mem_r [0:(1<<ADDR_W)-1];

  // write enabled bits only, untouched bits keep stored value
  always_ff @(posedge ref_clk) begin
    if (clk_en && wr_en) begin
      mem_r[wr_addr] <= (mem_r[wr_addr] & ~wr_bit_en) | (wr_data & wr_bit_en);
    end
  end

  // registered read port
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      rd_data <= mem_r[rd_addr];
    end
  end
endmodule
`default_nettype wire

// ---- sdp_port_sva.sv ----
// assertions on the read side of the sram port
`timescale 1ns/1ps
`default_nettype none
module sdp_port_sva #(
  parameter int DATA_W = 36
) (
  input wire logic              ref_clk,
  input wire logic              reset_n,
  input wire logic              k_phase,
  input wire logic              c_phase,
  input wire logic              single_clk_mode,
  input wire logic              load_strobe_n,
  input wire logic              read_not_write,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic              rd_data_oe_n
);
  logic [7:0] rd_age, ld_age, edge_age, low_cnt;
  logic       oclk_q;
  wire        oclk = single_clk_mode ? k_phase : c_phase;
  // saturating ages since a read load, any load and an output clock rise
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {rd_age, ld_age, edge_age} <= {3{8'hFF}};
      low_cnt <= 8'h00;
      oclk_q  <= 1'b0;
    end else begin
      oclk_q   <= oclk;
      rd_age   <= (!load_strobe_n && read_not_write) ? 8'h00 : rd_age + {7'h00, rd_age != 8'hFF};
      ld_age   <= !load_strobe_n ? 8'h00 : ld_age + {7'h00, ld_age != 8'hFF};
      edge_age <= (oclk && !oclk_q) ? 8'h00 : edge_age + {7'h00, edge_age != 8'hFF};
      low_cnt  <= rd_data_oe_n ? 8'h00 : low_cnt + 8'h01;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_two_words;
    !rd_data_oe_n [*2] ##[0:8] rd_data_oe_n;
  endsequence
  property p_burst; $fell(rd_data_oe_n) |-> s_two_words; endproperty
  a_burst: assert property (p_burst) else $error("read burst length wrong");
  property p_needs_read; $fell(rd_data_oe_n) |-> rd_age < 8'h18; endproperty
  a_needs_read: assert property (p_needs_read) else $error("drive without read");
  property p_after_edge; $fell(rd_data_oe_n) |-> edge_age < 8'h08; endproperty
  a_after_edge: assert property (p_after_edge) else $error("drive off clock");
  property p_quiet; ld_age > 8'h18 |-> rd_data_oe_n; endproperty
  a_quiet: assert property (p_quiet) else $error("drive with no load");
  property p_max_low; low_cnt < 8'h0C; endproperty
  a_max_low: assert property (p_max_low) else $error("drive too long");
  property p_idle_stable; rd_data_oe_n && $past(rd_data_oe_n) |-> $stable(rd_data); endproperty
  a_idle_stable: assert property (p_idle_stable) else $error("data moved idle");
  property p_reset_val; $rose(reset_n) |-> rd_data_oe_n && rd_data == '0; endproperty
  a_reset_val: assert property (p_reset_val) else $error("bad reset output");
  property p_end; $rose(rd_data_oe_n) |-> rd_age > 8'h03 && rd_age < 8'h20; endproperty
  a_end: assert property (p_end) else $error("release off time");
endmodule
bind sdp_port sdp_port_sva #(.DATA_W(DATA_W)) sdp_port_sva_inst (.ref_clk(ref_clk),
  .reset_n(reset_n), .k_phase(k_phase), .c_phase(c_phase), .single_clk_mode(single_clk_mode),
  .load_strobe_n(load_strobe_n), .read_not_write(read_not_write), .rd_data(rd_data),
  .rd_data_oe_n(rd_data_oe_n));
`default_nettype wire

// ---- sdp_ctrl_model.sv ----
// clock pair model for the controller side of the sram port
`timescale 1ns/1ps
`default_nettype none
module sdp_ctrl_model (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic single_clk_mode,
  output logic      k_phase,
  output logic      c_phase
);
  logic [1:0] cnt_r;
  // input clock half is four system cycles, above the three needed
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r   <= 2'h0;
      k_phase <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      if (cnt_r == 2'h3) k_phase <= ~k_phase;
    end
  end
  // output clock stands still in single clock mode
  assign c_phase = single_clk_mode ? 1'b0 : k_phase;
endmodule
`default_nettype wire

// ---- sdp_port_tb.sv ----
// self-checking bench for the sram port
`timescale 1ns/1ps
`default_nettype none
module sdp_port_tb;
  logic        ref_clk = 0, reset_n = 0, clk_en = 1, single_clk_mode = 0, oe_q = 1;
  logic        load_strobe_n = 1, read_not_write = 0, k_phase, c_phase, rd_data_oe_n;
  logic [18:0] addr = '0;
  logic [35:0] wr_data = '0, rd_data, mem [0:511], exp_q [$];
  logic [3:0]  write_mask_n = '0;
  int          miscompares = 0, check_count = 0, cycles = 0;
  integer      seed = 32'hB4237095;
  initial forever #12.5 ref_clk = ~ref_clk;
  sdp_ctrl_model sdp_ctrl_model_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .single_clk_mode(single_clk_mode), .k_phase(k_phase), .c_phase(c_phase));
  sdp_port sdp_port_inst (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
    .k_phase(k_phase), .c_phase(c_phase), .single_clk_mode(single_clk_mode),
    .load_strobe_n(load_strobe_n), .read_not_write(read_not_write), .addr(addr),
    .wr_data(wr_data), .write_mask_n(write_mask_n), .rd_data(rd_data),
    .rd_data_oe_n(rd_data_oe_n));
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (exp_q.size() != 0) miscompares++; // any read words never delivered count as one miss
    if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // wait for an input clock level, then one more edge
  task automatic half(input logic v);
    do @(posedge ref_clk); while (k_phase !== v);
    @(posedge ref_clk);
  endtask
  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] d,
                                        input logic [3:0] m);
    for (int i = 0; i < 4; i++) if (!m[i]) o[i*9 +: 9] = d[i*9 +: 9];
    return o;
  endfunction
  // one input clock period: word 0 before the rise, word 1 before the fall
  task automatic xfer(input logic ld_n, input logic rnw, input logic [7:0] a,
                      input logic [3:0] m0, input logic [3:0] m1);
    logic [35:0] d0, d1;
    d0 = 36'({$random(seed), $random(seed)});
    d1 = 36'({$random(seed), $random(seed)});
    half(1'b0);
    load_strobe_n  <= ld_n;
    read_not_write <= rnw;
    addr           <= {11'h000, a};
    wr_data        <= d0;
    write_mask_n   <= m0;
    half(1'b1);
    load_strobe_n  <= 1'b1;
    addr           <= ~addr;
    wr_data        <= d1;
    write_mask_n   <= m1;
    if (!ld_n && !rnw) begin
      mem[{a, 1'b0}] = merge(mem[{a, 1'b0}], d0, m0);
      mem[{a, 1'b1}] = merge(mem[{a, 1'b1}], d1, m1);
    end
    if (!ld_n && rnw) begin
      exp_q.push_back(mem[{a, 1'b0}]);
      exp_q.push_back(mem[{a, 1'b1}]);
    end
  endtask
  // drive start and end pick the next expected word; also cuts a hang
  always @(posedge ref_clk) begin
    oe_q <= rd_data_oe_n;
    if (reset_n && oe_q !== rd_data_oe_n) chk(rd_data, exp_q.size() ? exp_q.pop_front() : 'x);
    cycles++;
    if (cycles > 6000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    int r;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) xfer(1'b0, 1'b0, 8'(i), 4'h0, 4'h0);
    for (int n = 0; n < 48; n++) begin
      r = $random(seed) & 3;
      if (n == 24) single_clk_mode <= 1'b1;
      case (r)
        0, 1: xfer(1'b0, 1'b0, 8'($random(seed) & 7), 4'($random(seed)), 4'($random(seed)));
        2: begin
          xfer(1'b0, 1'b1, 8'($random(seed) & 7), 4'h0, 4'h0);
          xfer(1'b1, 1'b0, 8'h00, 4'h0, 4'h0);
          xfer(1'b1, 1'b1, 8'h01, 4'h0, 4'h0);
        end
        default: xfer(1'b1, 1'($random(seed)), 8'($random(seed) & 7), 4'h0, 4'h0);
      endcase
    end
    repeat (40) @(posedge ref_clk);
    wrap_up();
  end
endmodule
`default_nettype wire
